// File: pm_defs.svh
// Constants of the power-down and low-voltage reset sequencer.
// Assumes a 10 MHz aclk and a byte-addressed AXI4-Lite register window.
`ifndef PM_DEFS_SVH
`define PM_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define CTRL_ADDR 4'h0
`define STATUS_ADDR 4'h4
`define CTRL_RESET 7'h00
`define CTRL_KEY_LSB 0
`define CTRL_INT_BIT 4
`define CTRL_SEL_LO_BIT 5
`define CTRL_SEL_HI_BIT 6
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ----------------------------------------
// Timing and fixed values
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define OSC_SETTLE_NS 200000
`define OSC_SETTLE_CYC ((`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STACK_INIT_LEVEL 3'h7
`define CNTR_INPUT_SEL 2'h3

`endif

// File: pm_pkg.sv
// Types shared by the sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package pm_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_CLK_SLEEP = 3'b001,
        ST_DEEP_SLEEP = 3'b010,
        ST_OSC_WAIT = 3'b011,
        ST_WAKE = 3'b100
    } pm_state_t;
endpackage : pm_pkg

// File: osc_if.sv
// Handshake between the sequencer and its oscillator settle timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface osc_if;
    logic start;
    logic stable;
    modport seq (output start, input stable);
    modport timer (input start, output stable);
endinterface : osc_if
`default_nettype wire

// File: osc_settle_timer.sv
// Counts the oscillator restart time after a deep-sleep wake-up.
// Assumes start is held high for the whole wait.
`timescale 1ns/1ps
`default_nettype none
`include "pm_defs.svh"
module osc_settle_timer (
    input wire logic aclk,
    input wire logic aresetn,
    osc_if.timer osc
);
    import pm_pkg::*;

    localparam int SETTLE = `OSC_SETTLE_CYC;
    logic [11:0] count;
    logic [11:0] next_count;

    // ----------------------------------------
    // Settle counter
    // ----------------------------------------
    always_comb begin
        next_count = count;
        if (!osc.start) begin
            next_count = 12'h000;
        end else if (count != SETTLE[11:0]) begin
            next_count = count + 12'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 12'h000;
        end else begin
            count <= next_count;
        end
    end

    assign osc.stable = osc.start && (count == SETTLE[11:0]);
endmodule : osc_settle_timer
`default_nettype wire

// File: pm_sequencer.sv
// Power-down sequencer with low-voltage reset and AXI4-Lite registers.
// Assumes instruction strobes and watchdog come from aclk logic; pins are async.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pm_defs.svh"
module pm_sequencer (
    input wire logic aclk,
    input wire logic aresetn,
    // Instruction strobes, timer flag and watchdog reset from the core
    input wire logic detector_keep_alive_instr,
    input wire logic sleep_arm_instr,
    input wire logic clock_sleep_instr,
    input wire logic deep_sleep_instr,
    input wire logic long_timer_request_flag,
    input wire logic watchdog_reset,
    // Asynchronous pins
    input wire logic reset_pin_n,
    input wire logic low_voltage_detect,
    input wire logic int_wake_pin,
    input wire logic [3:0] key_wake_pin,
    // Core and peripheral control
    output logic system_reset,
    output logic cpu_hold,
    output logic warm_restart,
    output logic stack_init,
    output logic [2:0] stack_init_level,
    output logic power_down_flag,
    output logic detector_active,
    output logic subclock_run,
    output logic main_clock_run,
    output logic lcd_on,
    output logic long_timer_run,
    output logic short_timers_run,
    output pm_pkg::pm_state_t power_state,
    output logic counter_io_pin_out,
    output logic counter_io_pin_oe,
    // AXI4-Lite slave
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import pm_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [3:0] key_prev;
    logic [6:0] next_sync1;
    logic [6:0] next_sync2;
    logic [3:0] next_key_prev;

    always_comb begin
        next_sync1 = {reset_pin_n, low_voltage_detect, int_wake_pin, key_wake_pin};
        next_sync2 = sync1;
        next_key_prev = sync2[3:0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Idle pin levels, so no false low-voltage reset or wake after reset
            sync1 <= 7'h4f;
            sync2 <= 7'h4f;
            key_prev <= 4'hf;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            key_prev <= next_key_prev;
        end
    end

    logic pin_n_s;
    logic lvd_s;
    logic int_s;
    logic [3:0] key_fall;
    logic [6:0] ctrl;

    assign pin_n_s = sync2[6];
    assign lvd_s = sync2[5];
    assign int_s = sync2[4];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_key
            // Only a high-to-low edge counts; a held-low key does not rewake
            assign key_fall[gi] = ctrl[`CTRL_KEY_LSB + gi] && key_prev[gi] && !sync2[gi];
        end
    endgenerate

    logic ext_wake;
    assign ext_wake = (|key_fall) || (ctrl[`CTRL_INT_BIT] && int_s);

    // ----------------------------------------
    // Reset sources and sleep state machine
    // ----------------------------------------
    pm_state_t state;
    pm_state_t next_state;
    logic armed;
    logic keep_alive;
    logic pflag;
    logic sys_rst;
    logic warm;
    logic stk;
    logic next_armed;
    logic next_keep_alive;
    logic next_pflag;
    logic next_sys_rst;
    logic next_warm;
    logic next_stk;
    logic deep_exit;
    logic next_deep_exit;
    logic reset_event;
    logic lvd_on;

    osc_if osc ();

    osc_settle_timer u_settle (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc(osc.timer)
    );

    assign osc.start = (state == ST_OSC_WAIT);
    assign lvd_on = (state == ST_RUN) || (state == ST_WAKE) || keep_alive;
    // Pin low for a machine cycle is caught by the synchroniser
    assign reset_event = !pin_n_s || watchdog_reset || (lvd_s && lvd_on);

    always_comb begin
        next_state = state;
        next_armed = armed;
        next_keep_alive = keep_alive;
        next_pflag = pflag;
        next_sys_rst = reset_event;
        next_warm = 1'b0;
        next_stk = 1'b0;
        next_deep_exit = deep_exit;
        if (reset_event) begin
            next_state = ST_RUN;
            next_armed = 1'b0;
            next_keep_alive = 1'b0;
            next_pflag = 1'b0;
            next_deep_exit = 1'b0;
        end else begin
            if (detector_keep_alive_instr) begin
                next_keep_alive = 1'b1;
            end
            case (state)
                ST_RUN: begin
                    if (sleep_arm_instr) begin
                        next_armed = 1'b1;
                    end
                    // Unarmed sleep instructions fall through as no-ops
                    if (armed && clock_sleep_instr) begin
                        next_state = ST_CLK_SLEEP;
                        next_armed = 1'b0;
                    end else if (armed && deep_sleep_instr) begin
                        next_state = ST_DEEP_SLEEP;
                        next_armed = 1'b0;
                    end
                end
                ST_CLK_SLEEP: begin
                    // A flag already set on entry wakes on the next edge
                    if (ext_wake || long_timer_request_flag) begin
                        next_state = ST_WAKE;
                        next_deep_exit = 1'b0;
                    end
                end
                ST_DEEP_SLEEP: begin
                    // Oscillators are down, so the timer flag cannot wake
                    if (ext_wake) begin
                        next_state = ST_OSC_WAIT;
                    end
                end
                ST_OSC_WAIT: begin
                    if (osc.stable) begin
                        next_state = ST_WAKE;
                        next_deep_exit = 1'b1;
                    end
                end
                ST_WAKE: begin
                    // Control registers sit outside and are left alone
                    next_state = ST_RUN;
                    next_pflag = 1'b1;
                    next_warm = 1'b1;
                    next_stk = deep_exit;
                end
                default: begin
                    next_state = ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_RUN;
            armed <= 1'b0;
            keep_alive <= 1'b0;
            pflag <= 1'b0;
            sys_rst <= 1'b1;
            warm <= 1'b0;
            stk <= 1'b0;
            deep_exit <= 1'b0;
        end else begin
            state <= next_state;
            armed <= next_armed;
            keep_alive <= next_keep_alive;
            pflag <= next_pflag;
            sys_rst <= next_sys_rst;
            warm <= next_warm;
            stk <= next_stk;
            deep_exit <= next_deep_exit;
        end
    end

    assign system_reset = sys_rst;
    assign warm_restart = warm;
    assign stack_init = stk;
    assign stack_init_level = `STACK_INIT_LEVEL;
    // Read by the skip instruction to tell warm from cold
    assign power_down_flag = pflag;
    assign detector_active = lvd_on;
    assign power_state = state;
    assign cpu_hold = (state != ST_RUN);
    assign subclock_run = (state != ST_DEEP_SLEEP) && (state != ST_OSC_WAIT);
    assign main_clock_run = (state != ST_CLK_SLEEP) && (state != ST_DEEP_SLEEP);
    assign lcd_on = subclock_run;
    assign long_timer_run = subclock_run;
    // Short timers stop in either sleep, leaving their state undefined
    assign short_timers_run = (state == ST_RUN) || (state == ST_WAKE);

    // ----------------------------------------
    // Counter pin in deep sleep
    // ----------------------------------------
    logic [1:0] cntr_sel;
    logic deep_pin;
    assign cntr_sel = {ctrl[`CTRL_SEL_HI_BIT], ctrl[`CTRL_SEL_LO_BIT]};
    assign deep_pin = (state == ST_DEEP_SLEEP) || (state == ST_OSC_WAIT);
    // Outside deep sleep the counter block owns the pin; this drives low only
    assign counter_io_pin_out = 1'b0;
    assign counter_io_pin_oe = deep_pin && (cntr_sel != `CNTR_INPUT_SEL);

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic next_bvalid;
    logic next_rvalid;
    logic [1:0] next_bresp;
    logic [1:0] next_rresp;
    logic [31:0] next_rdata;
    logic [6:0] next_ctrl;
    logic wr_go;
    logic rd_go;

    // Both channels must be present; the slave simply waits for the later one
    assign awready = awvalid && wvalid && !bvalid;
    assign wready = awready;
    assign arready = !rvalid;
    assign wr_go = awready;
    assign rd_go = arvalid && arready;

    always_comb begin
        next_bvalid = bvalid && !bready;
        next_rvalid = rvalid && !rready;
        next_bresp = bresp;
        next_rresp = rresp;
        next_rdata = rdata;
        next_ctrl = ctrl;
        if (wr_go) begin
            next_bvalid = 1'b1;
            if (awaddr == `CTRL_ADDR) begin
                next_bresp = `RESP_OKAY;
                if (wstrb[0]) begin
                    next_ctrl = wdata[6:0];
                end
            end else if (awaddr == `STATUS_ADDR) begin
                next_bresp = `RESP_OKAY;
            end else begin
                next_bresp = `RESP_SLVERR;
            end
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            if (araddr == `CTRL_ADDR) begin
                next_rresp = `RESP_OKAY;
                next_rdata = {25'h0000000, ctrl};
            end else if (araddr == `STATUS_ADDR) begin
                next_rresp = `RESP_OKAY;
                next_rdata = {25'h0000000, lvd_on, pflag, keep_alive, armed, state};
            end else begin
                next_rresp = `RESP_SLVERR;
                next_rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            rvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rresp <= `RESP_OKAY;
            rdata <= 32'h00000000;
            ctrl <= `CTRL_RESET;
        end else begin
            bvalid <= next_bvalid;
            rvalid <= next_rvalid;
            bresp <= next_bresp;
            rresp <= next_rresp;
            rdata <= next_rdata;
            ctrl <= next_ctrl;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_deep_wake;
        state == ST_DEEP_SLEEP && ext_wake && !reset_event;
    endsequence

    sequence s_settled;
        state == ST_OSC_WAIT && osc.stable && !reset_event;
    endsequence

    a_lvd_reset: assert property (
        lvd_s && lvd_on |=> system_reset && state == ST_RUN && !power_down_flag)
        else $error("low voltage did not reset");
    a_lvd_sleep_off: assert property (
        (state == ST_CLK_SLEEP || state == ST_DEEP_SLEEP) && !keep_alive |-> !detector_active)
        else $error("detector active in sleep without keep-alive");
    a_keep_alive_sticky: assert property (
        keep_alive && !reset_event |=> keep_alive)
        else $error("keep-alive lost without reset");
    a_armed_entry: assert property (
        state == ST_RUN && armed && clock_sleep_instr && !reset_event
        |=> state == ST_CLK_SLEEP && !armed)
        else $error("armed clock sleep not entered");
    a_unarmed_nop: assert property (
        state == ST_RUN && !armed && (clock_sleep_instr || deep_sleep_instr)
        |=> state == ST_RUN)
        else $error("unarmed sleep changed state");
    a_timer_wake: assert property (
        state == ST_CLK_SLEEP && long_timer_request_flag && !reset_event
        |=> state == ST_WAKE ##1 warm_restart && power_down_flag)
        else $error("timer flag did not wake");
    a_deep_hold: assert property (
        state == ST_DEEP_SLEEP && !ext_wake && !reset_event |=> state == ST_DEEP_SLEEP)
        else $error("deep sleep left without external wake");
    a_osc_wait: assert property (
        s_deep_wake |=> state == ST_OSC_WAIT && cpu_hold)
        else $error("deep wake did not wait for oscillator");
    a_osc_early: assert property (
        state == ST_OSC_WAIT && !osc.stable && !reset_event
        |=> state == ST_OSC_WAIT && cpu_hold)
        else $error("cpu released before oscillator stable");
    a_stack_level: assert property (
        s_settled ##1 !reset_event |=> stack_init && stack_init_level == 3'h7)
        else $error("stack not initialised after deep sleep");
    a_cold_flag: assert property (
        !pin_n_s |=> system_reset && !power_down_flag)
        else $error("pin reset kept power-down flag");
    a_counter_pin: assert property (
        state == ST_DEEP_SLEEP |-> counter_io_pin_oe == (cntr_sel != 2'h3)
        && !counter_io_pin_out)
        else $error("counter pin wrong in deep sleep");
endmodule : pm_sequencer
`default_nettype wire

// File: power_down_and_low_voltage_reset_bench.sv
// Self-checking bench for the power-down and low-voltage reset sequencer.
// Assumes pm_defs.svh, pm_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pm_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module power_down_and_low_voltage_reset_bench;
    import pm_pkg::*;
    // ----------------------------------------
    // Signals and design
    // ----------------------------------------
    logic aclk, aresetn, long_timer_request_flag, watchdog_reset, reset_pin_n;
    logic low_voltage_detect, int_wake_pin, system_reset, cpu_hold, warm_restart;
    logic stack_init, power_down_flag, detector_active, subclock_run, main_clock_run;
    logic lcd_on, long_timer_run, short_timers_run, counter_io_pin_out, counter_io_pin_oe;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0] ins, key_wake_pin, awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d;
    logic [2:0] stack_init_level;
    logic [1:0] bresp, rresp, r;
    pm_state_t power_state;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    pm_sequencer u_pm_sequencer (
        .aclk, .aresetn, .detector_keep_alive_instr(ins[0]), .sleep_arm_instr(ins[1]),
        .clock_sleep_instr(ins[2]), .deep_sleep_instr(ins[3]), .long_timer_request_flag,
        .watchdog_reset, .reset_pin_n, .low_voltage_detect, .int_wake_pin, .key_wake_pin,
        .system_reset, .cpu_hold, .warm_restart, .stack_init, .stack_init_level,
        .power_down_flag, .detector_active, .subclock_run, .main_clock_run, .lcd_on,
        .long_timer_run, .short_timers_run, .power_state, .counter_io_pin_out,
        .counter_io_pin_oe, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready
    );
    typedef struct packed {
        logic arm;
        logic [3:0] ins;
        logic [1:0] wake;
        logic [2:0] st;
    } row_t;
    // Wake: 0 timer flag, 1 level pin, 2 key edge
    row_t rows [6] = '{
        '{1'b1, 4'h4, 2'h0, ST_CLK_SLEEP},
        '{1'b0, 4'h4, 2'h0, ST_RUN},
        '{1'b0, 4'h8, 2'h0, ST_RUN},
        '{1'b1, 4'h4, 2'h2, ST_CLK_SLEEP},
        '{1'b1, 4'h8, 2'h1, ST_DEEP_SLEEP},
        '{1'b1, 4'h8, 2'h2, ST_DEEP_SLEEP}
    };
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask : tick
    task automatic op(input logic [3:0] v);
        @(posedge aclk);
        ins <= v;
        @(posedge aclk);
        ins <= 4'h0;
    endtask : op
    // Bounded so a lost wake-up cannot hang the run
    task automatic wait_wake(output int k);
        k = 0;
        while (warm_restart !== 1'b1 && k < 3000) begin
            @(posedge aclk);
            k++;
        end
    endtask : wait_wake
    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic test_done;
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // Clock and timeout
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Four deep-sleep wakes of 2000 cycles each fit well inside this ceiling
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            $display("mismatch timeout exp 0 got 1");
            test_done;
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {ins, long_timer_request_flag, watchdog_reset, low_voltage_detect} = '0;
        {int_wake_pin, awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        reset_pin_n = 1'b1;
        key_wake_pin = 4'hf;
        tick(16);
        `CHK("rst", 1'b1, system_reset)
        aresetn <= 1'b1;
        tick(4);
        `CHK("rst", 1'b0, system_reset)
        `CHK("lvl", `STACK_INIT_LEVEL, stack_init_level)
        rd(`CTRL_ADDR, d, r);
        `CHK("ctrl", {25'h0, `CTRL_RESET}, d)
        rd(4'h8, d, r);
        `CHK("resp", `RESP_SLVERR, r)
        `CHK("rdata", 32'h0, d)
        wr(4'hc, 32'h7f, r);
        `CHK("resp", `RESP_SLVERR, r)
        wr(`STATUS_ADDR, 32'h7f, r);
        `CHK("resp", `RESP_OKAY, r)
        wr(`CTRL_ADDR, 32'h11, r);
        rd(`STATUS_ADDR, d, r);
        `CHK("status", 32'h40, d)
        foreach (rows[i]) begin
            // Sleep armed first for armed rows; unarmed sleep instructions must be ignored
            if (rows[i].arm) op(4'h2);
            op(rows[i].ins);
            tick(2);
            `CHK("state", rows[i].st, power_state)
            if (rows[i].st != ST_RUN) begin
                `CHK("hold", 1'b1, cpu_hold)
                `CHK("sub", rows[i].st == ST_CLK_SLEEP, subclock_run)
                `CHK("lcd", rows[i].st == ST_CLK_SLEEP, lcd_on)
                `CHK("ltmr", rows[i].st == ST_CLK_SLEEP, long_timer_run)
                `CHK("stmr", 1'b0, short_timers_run)
                `CHK("mclk", 1'b0, main_clock_run)
                long_timer_request_flag <= (rows[i].wake == 2'h0);
                int_wake_pin <= (rows[i].wake == 2'h1);
                key_wake_pin <= {3'h7, rows[i].wake != 2'h2};
                wait_wake(n);
                `CHK("wake", 1'b1, warm_restart)
                `CHK("pdf", 1'b1, power_down_flag)
                `CHK("stk", rows[i].st == ST_DEEP_SLEEP, stack_init)
                `CHK("settle", rows[i].st == ST_DEEP_SLEEP, n > 1999)
                `CHK("hold", 1'b0, cpu_hold)
                // Software reloads the undefined timer flag after waking
                long_timer_request_flag <= 1'b0;
                int_wake_pin <= 1'b0;
                key_wake_pin <= 4'hf;
                tick(4);
            end
        end
        op(4'h2);
        op(4'h8);
        long_timer_request_flag <= 1'b1;
        low_voltage_detect <= 1'b1;
        tick(20);
        `CHK("state", ST_DEEP_SLEEP, power_state)
        `CHK("det", 1'b0, detector_active)
        `CHK("lvr", 1'b0, system_reset)
        `CHK("cpo", 1'b0, counter_io_pin_out)
        `CHK("cpe", 1'b1, counter_io_pin_oe)
        low_voltage_detect <= 1'b0;
        wr(`CTRL_ADDR, 32'h71, r);
        tick(2);
        `CHK("cpe", 1'b0, counter_io_pin_oe)
        int_wake_pin <= 1'b1;
        wait_wake(n);
        `CHK("wake", 1'b1, warm_restart)
        int_wake_pin <= 1'b0;
        rd(`CTRL_ADDR, d, r);
        `CHK("ctrl", 32'h71, d)
        // Low byte strobe off: the control register must not change
        wstrb <= 4'he;
        wr(`CTRL_ADDR, 32'h00, r);
        wstrb <= 4'hf;
        rd(`CTRL_ADDR, d, r);
        `CHK("ctrl", 32'h71, d)
        op(4'h2);
        op(4'h4);
        wait_wake(n);
        `CHK("early", 1'b1, n < 8)
        long_timer_request_flag <= 1'b0;
        watchdog_reset <= 1'b1;
        tick(2);
        `CHK("wdr", 1'b1, system_reset)
        watchdog_reset <= 1'b0;
        tick(4);
        `CHK("pdf", 1'b0, power_down_flag)
        wr(`CTRL_ADDR, 32'h11, r);
        op(4'h1);
        op(4'h2);
        op(4'h8);
        tick(2);
        `CHK("det", 1'b1, detector_active)
        low_voltage_detect <= 1'b1;
        tick(5);
        `CHK("lvr", 1'b1, system_reset)
        `CHK("state", ST_RUN, power_state)
        low_voltage_detect <= 1'b0;
        tick(6);
        wr(`CTRL_ADDR, 32'h11, r);
        op(4'h2);
        op(4'h8);
        tick(2);
        `CHK("det", 1'b0, detector_active)
        int_wake_pin <= 1'b1;
        wait_wake(n);
        `CHK("pdf", 1'b1, power_down_flag)
        int_wake_pin <= 1'b0;
        reset_pin_n <= 1'b0;
        tick(5);
        `CHK("pin", 1'b1, system_reset)
        `CHK("pdf", 1'b0, power_down_flag)
        reset_pin_n <= 1'b1;
        tick(6);
        `CHK("pin", 1'b0, system_reset)
        test_done;
    end
endmodule : power_down_and_low_voltage_reset_bench
`default_nettype wire
